// File: design/ch_cfg_pkg.sv
/*
 Constants, reset values, field layouts and helper functions for the
 channel configuration register bank on configuration page zero.
 Assumes a single control-port clock and a synchronous active-low reset.
*/
// What this block does
// - Analog gain field 0..42 dB, above reserved
// - Volume code zero mutes channel output
// - Volume in half-dB steps, 201 unity
// - Fine trim 0.1 dB steps, 8 unity
// - Phase delay counts modulator cycles, 0..255
// - Enable bit turns on range enhancer or gain control, reg 108 bit 3 picks which
// - Impedance select 2.5k, 10k, 20k, 3 reserved
// - Channel 3 bit 7 selects mic or line
// - Registers decoded 0x41..0x46 on page zero
package ch_cfg_pkg;

    localparam int          DATA_W          = 8;
    localparam int          SAMPLE_W        = 16;
    localparam int          DELAY_DEPTH     = 256;
    localparam int          PTR_W           = 8;

    localparam logic [7:0]  PAGE_CFG        = 8'h00;
    localparam logic [7:0]  ADDR_CH2_INPUT  = 8'h41;
    localparam logic [7:0]  ADDR_CH2_ANALOG_GAIN   = 8'h42;
    localparam logic [7:0]  ADDR_CH2_VOL    = 8'h43;
    localparam logic [7:0]  ADDR_CH2_TRIM   = 8'h44;
    localparam logic [7:0]  ADDR_CH2_PHASE  = 8'h45;
    localparam logic [7:0]  ADDR_CH3_INPUT  = 8'h46;

    localparam logic [7:0]  RST_CH2_INPUT   = 8'h00;
    localparam logic [7:0]  RST_CH2_ANALOG_GAIN    = 8'h00;
    localparam logic [7:0]  RST_CH2_VOL     = 8'hc9;
    localparam logic [7:0]  RST_CH2_TRIM    = 8'h80;
    localparam logic [7:0]  RST_CH2_PHASE   = 8'h00;
    localparam logic [7:0]  RST_CH3_INPUT   = 8'h00;

    localparam logic [7:0]  MASK_CH2_INPUT  = 8'h0d;
    localparam logic [7:0]  MASK_CH2_ANALOG_GAIN   = 8'hfc;
    localparam logic [7:0]  MASK_CH2_VOL    = 8'hff;
    localparam logic [7:0]  MASK_CH2_TRIM   = 8'hf0;
    localparam logic [7:0]  MASK_CH2_PHASE  = 8'hff;
    localparam logic [7:0]  MASK_CH3_INPUT  = 8'h80;

    localparam int          GAIN_LSB        = 2;
    localparam int          TRIM_LSB        = 4;
    localparam int          IMP_LSB         = 2;
    localparam int          ENH_BIT         = 0;
    localparam int          KIND_BIT        = 7;
    localparam int          R108_SEL_BIT    = 3;

    localparam logic [5:0]  GAIN_MAX        = 6'h2a;
    localparam logic [7:0]  VOL_MUTE        = 8'h00;
    localparam logic [8:0]  VOL_UNITY       = 9'h0c9;
    localparam logic [4:0]  TRIM_UNITY      = 5'h08;
    localparam logic [1:0]  IMP_RESERVED    = 2'h3;
    localparam logic [1:0]  IMP_DEFAULT     = 2'h0;

    // True when an access targets the given address on the config page.
    function automatic logic reg_hit(input logic [7:0] page,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
        reg_hit = (page == PAGE_CFG) && (addr == target);
    endfunction : reg_hit

    // Next value of a register: masked write data or the held value.
    function automatic logic [7:0] reg_next(input logic       hit,
                                            input logic [7:0] wdata,
                                            input logic [7:0] mask,
                                            input logic [7:0] cur);
        reg_next = hit ? (wdata & mask) : cur;
    endfunction : reg_next

endpackage : ch_cfg_pkg

// File: design/delay_mem.sv
/*
 Dual-port-style delay memory for the phase calibration line: one
 write and one registered read per clock.
 Assumes the caller keeps both addresses in range and reads old data.
*/
`timescale 1ns/100ps
`default_nettype none
module delay_mem
    import ch_cfg_pkg::*;
(
    input  wire logic                   clk,    // Control-port clock.
    input  wire logic                   acc_en, // Write and read enable.
    input  wire logic [PTR_W-1:0]       waddr,  // Write address.
    input  wire logic                   wbit,   // Write data.
    input  wire logic [PTR_W-1:0]       raddr,  // Read address.
    output logic                        rbit_ff // Registered read data.
);
    import ch_cfg_pkg::*;

    logic                               mem [DELAY_DEPTH];

    // Read happens before the write of the same edge lands.
    always_ff @(posedge clk)
    begin
        if (acc_en)
        begin
            mem[waddr] <= wbit;
            rbit_ff    <= mem[raddr];
        end
    end

endmodule : delay_mem
`default_nettype wire

// File: design/audio_channel_config_regs.sv
/*
 Channel 2 configuration registers and the first channel 3 input
 setting, with the channel controls that they steer: analog gain,
 volume and mute, fine trim, phase delay, impedance and enhancer select.
 Assumes the control port presents one access per cycle synchronously,
 and that modulator ticks are one-cycle strobes of clk.
*/
`timescale 1ns/100ps
`default_nettype none
module audio_channel_config_regs
    import ch_cfg_pkg::*;
(
    input  wire logic                       clk,           // Clock.
    input  wire logic                       rst_b,         // Sync reset.
    input  wire logic [7:0]                 ctl_page,      // Page select.
    input  wire logic [7:0]                 ctl_addr,      // Reg address.
    input  wire logic                       ctl_wr,        // Write strobe.
    input  wire logic                       ctl_rd,        // Read strobe.
    input  wire logic [7:0]                 ctl_wdata,     // Write data.
    output logic [7:0]                      ctl_rdata_ff,  // Read data.
    input  wire logic [7:0]                 page0_reg_108, // Mode reg.
    input  wire logic                       mod_tick,      // Mod clock.
    input  wire logic                       mod_bit,       // Mod stream.
    output logic                            mod_bit_delayed, // Delayed.
    input  wire logic                       sample_valid,  // Sample strobe.
    input  wire logic [SAMPLE_W-1:0]        sample_in,     // Sample.
    output logic                            sample_out_valid, // Out strobe.
    output logic [SAMPLE_W-1:0]             sample_out,    // Out sample.
    output logic [1:0]                      ch2_impedance_select, // Imp.
    output logic                            ch2_range_enhance_enable, // En.
    output logic                            dynamic_range_enhancer, // On.
    output logic                            automatic_gain_control, // On.
    output logic [5:0]                      ch2_analog_gain, // dB.
    output logic [7:0]                      ch2_volume_code, // Code.
    output logic                            ch2_mute,      // Muted.
    output logic signed [8:0]               ch2_volume_half_db, // 0.5 dB.
    output logic [3:0]                      ch2_fine_gain_trim, // Code.
    output logic signed [4:0]               ch2_trim_tenth_db, // 0.1 dB.
    output logic [7:0]                      ch2_phase_delay_cycles, // Cyc.
    output logic                            ch3_input_kind // 1 = line.
);
    import ch_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    logic [7:0]                             ch2_input_setup_ff;
    logic [7:0]                             ch2_analog_gain_select_ff;
    logic [7:0]                             ch2_volume_level_ff;
    logic [7:0]                             ch2_analog_gain_trim_ff;
    logic [7:0]                             ch2_phase_delay_ff;
    logic [7:0]                             ch3_input_setup_ff;

    wire logic hit_in2   = reg_hit(ctl_page, ctl_addr, ADDR_CH2_INPUT);
    wire logic hit_gain  = reg_hit(ctl_page, ctl_addr, ADDR_CH2_ANALOG_GAIN);
    wire logic hit_vol   = reg_hit(ctl_page, ctl_addr, ADDR_CH2_VOL);
    wire logic hit_trim  = reg_hit(ctl_page, ctl_addr, ADDR_CH2_TRIM);
    wire logic hit_phase = reg_hit(ctl_page, ctl_addr, ADDR_CH2_PHASE);
    wire logic hit_in3   = reg_hit(ctl_page, ctl_addr, ADDR_CH3_INPUT);

    // Masks drop reserved and out-of-scope positions on every write.
    wire logic [7:0] nxt_ch2_input_setup = reg_next(ctl_wr && hit_in2,
        ctl_wdata, MASK_CH2_INPUT, ch2_input_setup_ff);
    wire logic [7:0] nxt_ch2_analog_gain_select = reg_next(ctl_wr && hit_gain,
        ctl_wdata, MASK_CH2_ANALOG_GAIN, ch2_analog_gain_select_ff);
    wire logic [7:0] nxt_ch2_volume_level = reg_next(ctl_wr && hit_vol,
        ctl_wdata, MASK_CH2_VOL, ch2_volume_level_ff);
    wire logic [7:0] nxt_ch2_analog_gain_trim = reg_next(ctl_wr && hit_trim,
        ctl_wdata, MASK_CH2_TRIM, ch2_analog_gain_trim_ff);
    wire logic [7:0] nxt_ch2_phase_delay = reg_next(ctl_wr && hit_phase,
        ctl_wdata, MASK_CH2_PHASE, ch2_phase_delay_ff);
    wire logic [7:0] nxt_ch3_input_setup = reg_next(ctl_wr && hit_in3,
        ctl_wdata, MASK_CH3_INPUT, ch3_input_setup_ff);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ch2_input_setup_ff  <= RST_CH2_INPUT;
            ch2_analog_gain_select_ff  <= RST_CH2_ANALOG_GAIN;
            ch2_volume_level_ff <= RST_CH2_VOL;
            ch2_analog_gain_trim_ff    <= RST_CH2_TRIM;
            ch2_phase_delay_ff  <= RST_CH2_PHASE;
            ch3_input_setup_ff  <= RST_CH3_INPUT;
        end
        else
        begin
            ch2_input_setup_ff  <= nxt_ch2_input_setup;
            ch2_analog_gain_select_ff  <= nxt_ch2_analog_gain_select;
            ch2_volume_level_ff <= nxt_ch2_volume_level;
            ch2_analog_gain_trim_ff    <= nxt_ch2_analog_gain_trim;
            ch2_phase_delay_ff  <= nxt_ch2_phase_delay;
            ch3_input_setup_ff  <= nxt_ch3_input_setup;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Unmapped addresses and other pages read as zero.
    wire logic [7:0] read_mux =
        hit_in2   ? ch2_input_setup_ff  :
        hit_gain  ? ch2_analog_gain_select_ff  :
        hit_vol   ? ch2_volume_level_ff :
        hit_trim  ? ch2_analog_gain_trim_ff    :
        hit_phase ? ch2_phase_delay_ff  :
        hit_in3   ? ch3_input_setup_ff  : 8'h00;

    wire logic [7:0] nxt_ctl_rdata = ctl_rd ? read_mux : ctl_rdata_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ctl_rdata_ff <= 8'h00;
        else
            ctl_rdata_ff <= nxt_ctl_rdata;
    end

    ////////////////////////////////////////////////////////////////////////

    wire logic [5:0] gain_field = ch2_analog_gain_select_ff[GAIN_LSB +: 6];
    wire logic [1:0] imp_field  = ch2_input_setup_ff[IMP_LSB +: 2];

    // Reserved gain codes saturate at the top legal step.
    assign ch2_analog_gain = (gain_field > GAIN_MAX) ? GAIN_MAX
                                                     : gain_field;
    // The reserved impedance code falls back to the lowest setting.
    assign ch2_impedance_select = (imp_field == IMP_RESERVED) ? IMP_DEFAULT
                                                              : imp_field;
    assign ch2_volume_code    = ch2_volume_level_ff;
    assign ch2_mute           = (ch2_volume_level_ff == VOL_MUTE);
    assign ch2_volume_half_db = ch2_mute ? 9'sh000 :
        $signed({1'b0, ch2_volume_level_ff} - VOL_UNITY);
    assign ch2_fine_gain_trim = ch2_analog_gain_trim_ff[TRIM_LSB +: 4];
    assign ch2_trim_tenth_db  =
        $signed({1'b0, ch2_fine_gain_trim} - TRIM_UNITY);
    assign ch2_phase_delay_cycles = ch2_phase_delay_ff;
    assign ch2_range_enhance_enable = ch2_input_setup_ff[ENH_BIT];
    assign dynamic_range_enhancer = ch2_range_enhance_enable &&
        !page0_reg_108[R108_SEL_BIT];
    assign automatic_gain_control = ch2_range_enhance_enable &&
        page0_reg_108[R108_SEL_BIT];
    assign ch3_input_kind = ch3_input_setup_ff[KIND_BIT];

    ////////////////////////////////////////////////////////////////////////

    logic [SAMPLE_W-1:0]                    sample_out_ff;
    logic                                   sample_valid_ff;

    wire logic [SAMPLE_W-1:0] nxt_sample_out =
        !sample_valid ? sample_out_ff :
        ch2_mute      ? '0 : sample_in;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sample_out_ff   <= '0;
            sample_valid_ff <= 1'b0;
        end
        else
        begin
            sample_out_ff   <= nxt_sample_out;
            sample_valid_ff <= sample_valid;
        end
    end

    assign sample_out       = sample_out_ff;
    assign sample_out_valid = sample_valid_ff;

    ////////////////////////////////////////////////////////////////////////

    // The memory read at write pointer minus delay returns the bit that
    // was written that many ticks earlier; zero delay bypasses it.
    logic [PTR_W-1:0]                       wr_ptr_ff;
    logic                                   bit_now_ff;
    logic                                   zero_delay_ff;
    logic                                   mem_bit;

    wire logic [PTR_W-1:0] rd_ptr = wr_ptr_ff - ch2_phase_delay_ff;
    wire logic [PTR_W-1:0] nxt_wr_ptr = mod_tick ? wr_ptr_ff + 8'h01
                                                 : wr_ptr_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wr_ptr_ff     <= '0;
            bit_now_ff    <= 1'b0;
            zero_delay_ff <= 1'b1;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            if (mod_tick)
            begin
                bit_now_ff    <= mod_bit;
                zero_delay_ff <= (ch2_phase_delay_ff == 8'h00);
            end
        end
    end

    delay_mem u_delay_mem
    (
        .clk     (clk),
        .acc_en  (mod_tick),
        .waddr   (wr_ptr_ff),
        .wbit    (mod_bit),
        .raddr   (rd_ptr),
        .rbit_ff (mem_bit)
    );

    assign mod_bit_delayed = zero_delay_ff ? bit_now_ff : mem_bit;

    ////////////////////////////////////////////////////////////////////////

    logic                                   prev_tick_bit_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            prev_tick_bit_ff <= 1'b0;
        else if (mod_tick)
            prev_tick_bit_ff <= mod_bit;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    gain_clamp_a: assert property (
        ctl_wr && hit_gain |=> ch2_analog_gain <= GAIN_MAX &&
        ch2_analog_gain == (($past(ctl_wdata[7:2]) > GAIN_MAX) ? GAIN_MAX
                                                    : $past(ctl_wdata[7:2])))
        else $error("analog gain not taken from write");
    mute_out_a: assert property (
        sample_valid && ch2_mute |=> sample_out == '0 && sample_out_valid)
        else $error("muted channel passed a sample");
    vol_step_a: assert property (
        ctl_wr && hit_vol && ctl_wdata != 8'h00 |=>
        ch2_volume_half_db == $signed({1'b0, $past(ctl_wdata)} - VOL_UNITY))
        else $error("volume half-dB value wrong after write");
    trim_step_a: assert property (
        ctl_wr && hit_trim |=> ch2_trim_tenth_db ==
        $signed({1'b0, $past(ctl_wdata[7:4])} - TRIM_UNITY))
        else $error("trim value wrong after write");
    phase_zero_a: assert property (
        mod_tick && ch2_phase_delay_ff == 8'h00 |=>
        mod_bit_delayed == $past(mod_bit))
        else $error("zero phase delay not a bypass");
    phase_one_a: assert property (
        mod_tick && ch2_phase_delay_ff == 8'h01 |=>
        mod_bit_delayed == $past(prev_tick_bit_ff))
        else $error("one-cycle phase delay wrong");
    enh_select_a: assert property (
        ctl_wr && hit_in2 |=>
        (dynamic_range_enhancer || automatic_gain_control) ==
        $past(ctl_wdata[ENH_BIT]) &&
        !(dynamic_range_enhancer && automatic_gain_control))
        else $error("enhancer and gain control select wrong");
    imp_reserved_a: assert property (
        ctl_wr && hit_in2 |=> ch2_impedance_select ==
        (($past(ctl_wdata[3:2]) == IMP_RESERVED) ? IMP_DEFAULT
                                                 : $past(ctl_wdata[3:2])))
        else $error("impedance select wrong after write");
    kind_bit_a: assert property (
        ctl_wr && hit_in3 |=> ch3_input_kind == $past(ctl_wdata[7]))
        else $error("input kind not taken from bit 7");
    page_decode_a: assert property (
        ctl_wr && ctl_page != PAGE_CFG |=> $stable(ch2_volume_level_ff)
        && $stable(ch2_phase_delay_ff) && $stable(ch2_analog_gain_select_ff))
        else $error("write on another page changed a register");
    rsvd_read_a: assert property (
        ctl_rd && hit_trim |=> ctl_rdata_ff[3:0] == 4'h0)
        else $error("reserved trim bits read nonzero");

    mute_seen_c:   cover property (sample_valid && ch2_mute);
    delay_seen_c:  cover property (mod_tick && ch2_phase_delay_ff > 8'h01);
    agc_seen_c:    cover property (automatic_gain_control);
    vol_write_c:   cover property (ctl_wr && hit_vol ##1 ctl_rd && hit_vol);

endmodule : audio_channel_config_regs
`default_nettype wire

// File: sim/audio_channel_config_regs_bench.sv
/*
 Self-checking bench for the channel configuration register bank: it
 drives the control port, the sample path and the modulator stream.
 Assumes the design package is compiled first and that the bench owns
 every input of the design.
*/
`timescale 1ns/100ps
`default_nettype none
module audio_channel_config_regs_bench;
    import ch_cfg_pkg::*;

    logic                  clk           = 1'b0;
    logic                  rst_b         = 1'b0;
    logic [7:0]            ctl_page      = 8'h00;
    logic [7:0]            ctl_addr      = 8'h00;
    logic                  ctl_wr        = 1'b0;
    logic                  ctl_rd        = 1'b0;
    logic [7:0]            ctl_wdata     = 8'h00;
    logic [7:0]            page0_reg_108 = 8'h00;
    logic                  mod_tick      = 1'b0;
    logic                  mod_bit       = 1'b0;
    logic                  sample_valid  = 1'b0;
    logic [SAMPLE_W-1:0]   sample_in     = '0;
    logic [7:0]            ctl_rdata_ff;
    logic                  mod_bit_delayed, sample_out_valid, ch2_mute;
    logic [SAMPLE_W-1:0]   sample_out;
    logic [1:0]            ch2_impedance_select;
    logic                  ch2_range_enhance_enable, ch3_input_kind;
    logic                  dynamic_range_enhancer, automatic_gain_control;
    logic [5:0]            ch2_analog_gain;
    logic [7:0]            ch2_volume_code, ch2_phase_delay_cycles;
    logic signed [8:0]     ch2_volume_half_db;
    logic [3:0]            ch2_fine_gain_trim;
    logic signed [4:0]     ch2_trim_tenth_db;
    int                    n_mismatch    = 0;
    int                    n_compared    = 0;
    logic [7:0]            radr [6] =
        '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46};
    logic [7:0]            rrst [6] =
        '{8'h00, 8'h00, 8'hc9, 8'h80, 8'h00, 8'h00};
    logic [7:0]            rmsk [6] =
        '{8'h0d, 8'hfc, 8'hff, 8'hf0, 8'hff, 8'h80};

    always #5 clk = ~clk;

    audio_channel_config_regs dut (.clk(clk), .rst_b(rst_b),
        .ctl_page(ctl_page), .ctl_addr(ctl_addr), .ctl_wr(ctl_wr),
        .ctl_rd(ctl_rd), .ctl_wdata(ctl_wdata), .ctl_rdata_ff(ctl_rdata_ff),
        .page0_reg_108(page0_reg_108), .mod_tick(mod_tick),
        .mod_bit(mod_bit), .mod_bit_delayed(mod_bit_delayed),
        .sample_valid(sample_valid), .sample_in(sample_in),
        .sample_out_valid(sample_out_valid), .sample_out(sample_out),
        .ch2_impedance_select(ch2_impedance_select),
        .ch2_range_enhance_enable(ch2_range_enhance_enable),
        .dynamic_range_enhancer(dynamic_range_enhancer),
        .automatic_gain_control(automatic_gain_control),
        .ch2_analog_gain(ch2_analog_gain), .ch2_volume_code(ch2_volume_code),
        .ch2_mute(ch2_mute), .ch2_volume_half_db(ch2_volume_half_db),
        .ch2_fine_gain_trim(ch2_fine_gain_trim),
        .ch2_trim_tenth_db(ch2_trim_tenth_db),
        .ch2_phase_delay_cycles(ch2_phase_delay_cycles),
        .ch3_input_kind(ch3_input_kind));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [15:0] exp,
                         input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // Strobes are left as set so that accesses can run back to back.
    task automatic acc(input logic w, input logic r, input logic [7:0] pg,
                       input logic [7:0] a, input logic [7:0] d);
        ctl_wr = w;
        ctl_rd = r;
        ctl_page = pg;
        ctl_addr = a;
        ctl_wdata = d;
        @(posedge clk);
        #1;
    endtask : acc

    task automatic idle;
        acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    endtask : idle

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [7:0] exp);
        acc(1'b0, 1'b1, 8'h00, a, 8'h00);
        check(nm, {8'h00, exp}, {8'h00, ctl_rdata_ff});
    endtask : rd_chk

    task automatic end_test(input string nm);
        idle();
        $display("test %s done", nm);
    endtask : end_test

    // Stream pattern of period 32 whose polarity flips after tick 100.
    function automatic logic pat(input int i);
        return i[1] ^ i[4] ^ (i > 100);
    endfunction : pat

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        int gc [4] = '{0, 42, 43, 63};
        int vc [4] = '{0, 1, 201, 255};
        int vh [4] = '{0, -200, 0, 54};
        int tc [3] = '{0, 8, 15};
        int dl [4] = '{0, 1, 3, 255};
        repeat (20) @(posedge clk);
        #1;
        rst_b = 1'b1;
        for (int k = 0; k < 6; k++)
            rd_chk("reset value", radr[k], rrst[k]);
        for (int k = 0; k < 6; k++)
        begin
            acc(1'b1, 1'b0, 8'h00, radr[k], 8'hff);
            rd_chk("reserved bits", radr[k], rmsk[k]);
        end
        rd_chk("unmapped 0x47", 8'h47, 8'h00);
        rd_chk("unmapped 0x40", 8'h40, 8'h00);
        acc(1'b1, 1'b0, 8'h01, 8'h43, 8'h00);
        rd_chk("other page write", 8'h43, 8'hff);
        acc(1'b0, 1'b1, 8'h01, 8'h43, 8'h00);
        check("other page read", 16'h0000, {8'h00, ctl_rdata_ff});
        acc(1'b1, 1'b1, 8'h00, 8'h43, 8'h10);
        check("read beside write", 16'h00ff, {8'h00, ctl_rdata_ff});
        end_test("map");
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b1, 1'b0, 8'h00, 8'h42, 8'(gc[k] << 2) | 8'h03);
            rd_chk("gain readback", 8'h42, 8'(gc[k] << 2));
            check("analog gain", 16'(gc[k] > 42 ? 42 : gc[k]),
                  16'(ch2_analog_gain));
        end
        end_test("gain");
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b1, 1'b0, 8'h00, 8'h43, 8'(vc[k]));
            idle();
            check("volume code", 16'(vc[k]), 16'(ch2_volume_code));
            check("mute", 16'(vc[k] == 0), 16'(ch2_mute));
            check("volume half db", 16'(vh[k]), ch2_volume_half_db);
            sample_valid = 1'b1;
            sample_in = 16'h5a3c;
            @(posedge clk);
            #1;
            sample_valid = 1'b0;
            check("sample valid", 16'h0001, 16'(sample_out_valid));
            check("sample out", vc[k] == 0 ? 16'h0000 : 16'h5a3c,
                  sample_out);
        end
        end_test("volume");
        check("sample valid low", 16'h0000, 16'(sample_out_valid));
        check("sample out held", 16'h5a3c, sample_out);
        for (int k = 0; k < 3; k++)
        begin
            acc(1'b1, 1'b0, 8'h00, 8'h44, 8'(tc[k] << 4) | 8'h0f);
            rd_chk("trim readback", 8'h44, 8'(tc[k] << 4));
            check("trim code", 16'(tc[k]), 16'(ch2_fine_gain_trim));
            check("trim tenth db", 16'(tc[k] - 8), ch2_trim_tenth_db);
        end
        end_test("trim");
        for (int c = 0; c < 4; c++)
        begin
            acc(1'b1, 1'b0, 8'h00, 8'h41, 8'(c << 2));
            rd_chk("impedance readback", 8'h41, 8'(c << 2));
            check("impedance", 16'(c == 3 ? 0 : c),
                  16'(ch2_impedance_select));
        end
        acc(1'b1, 1'b0, 8'h00, 8'h41, 8'h01);
        idle();
        check("enhance enable", 16'h0001, 16'(ch2_range_enhance_enable));
        check("enhancer on", 16'h0001, 16'(dynamic_range_enhancer));
        check("agc off", 16'h0000, 16'(automatic_gain_control));
        page0_reg_108 = 8'h08;
        idle();
        check("enhancer off", 16'h0000, 16'(dynamic_range_enhancer));
        check("agc on", 16'h0001, 16'(automatic_gain_control));
        acc(1'b1, 1'b0, 8'h00, 8'h41, 8'h00);
        check("agc disabled", 16'h0000, 16'(automatic_gain_control));
        check("dre disabled", 16'h0000, 16'(dynamic_range_enhancer));
        page0_reg_108 = 8'hf7;
        acc(1'b1, 1'b0, 8'h00, 8'h41, 8'h01);
        check("enhancer by bit", 16'h0001, 16'(dynamic_range_enhancer));
        end_test("input setup");
        acc(1'b1, 1'b0, 8'h00, 8'h46, 8'hff);
        check("line input", 16'h0001, 16'(ch3_input_kind));
        acc(1'b1, 1'b0, 8'h00, 8'h46, 8'h7f);
        rd_chk("mic readback", 8'h46, 8'h00);
        check("mic input", 16'h0000, 16'(ch3_input_kind));
        end_test("channel 3");
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b1, 1'b0, 8'h00, 8'h45, 8'(dl[k]));
            idle();
            check("delay cycles", 16'(dl[k]),
                  16'(ch2_phase_delay_cycles));
            for (int i = 0; i < dl[k] + 12; i++)
            begin
                mod_tick = 1'b1;
                mod_bit = pat(i);
                @(posedge clk);
                #1;
                if (i >= dl[k])
                    check("delayed bit", 16'(pat(i - dl[k])),
                          16'(mod_bit_delayed));
            end
            mod_tick = 1'b0;
        end
        end_test("phase delay");
        rst_b = 1'b0;
        idle();
        check("reset read data", 16'h0000, {8'h00, ctl_rdata_ff});
        rst_b = 1'b1;
        rd_chk("reset volume", 8'h43, 8'hc9);
        check("reset delayed bit", 16'h0000, 16'(mod_bit_delayed));
        end_test("second reset");
        report_and_stop();
    end

endmodule : audio_channel_config_regs_bench
`default_nettype wire
